// File: csta_common_signals.sv
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "csta_defines.svh"

module csta_common_signals
  import csta_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CSTA_MS_CYCLES
)
(
  input  wire logic        SYS_CLK,        // 125 MHz clock
  input  wire logic        NRST,           // Sync reset, low
  input  wire logic        PSEL,           // APB select
  input  wire logic        PENABLE,        // APB enable
  input  wire logic        PWRITE,         // APB direction
  input  wire logic [7:0]  PADDR,          // APB byte address
  input  wire logic [31:0] PWDATA,         // APB write data
  output logic      [31:0] PRDATA,         // APB read data
  output logic             PREADY,         // APB ready
  output logic             PSLVERR,        // APB error
  input  wire logic [15:0] PROT_START,     // Protection starts
  input  wire logic [15:0] PROT_TRIP,      // Protection trips
  input  wire logic        EXTRA_START_IN, // Assigned extra start pin
  input  wire logic        EXTRA_TRIP_IN,  // Assigned extra trip pin
  input  wire logic        STAGE_FORCE_EN, // Device test forcing enable
  input  wire logic [31:0] PROC_DATA,      // Process data snapshot
  output logic             COMMON_START,   // Common start
  output logic             COMMON_TRIP,    // Common trip
  output csta_evt_s        EVT,            // Logged record
  output logic             EVT_VALID,      // Common buffer write pulse
  output logic             MAIN_EVT_VALID, // Main buffer write pulse
  output logic             IRQ             // Interrupt level
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic csta_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == `CSTA_OFS_CTRL)
      hit = 1'b1;
    else if (a == `CSTA_OFS_EVT_SEL)
      hit = 1'b1;
    else if (a == `CSTA_OFS_COND)
      hit = 1'b1;
    else if (a == `CSTA_OFS_START_CNT)
      hit = 1'b1;
    else if (a == `CSTA_OFS_TRIP_CNT)
      hit = 1'b1;
    else if (a == `CSTA_OFS_TIME_MS)
      hit = 1'b1;
    else if (a == `CSTA_OFS_IRQ_STAT)
      hit = 1'b1;
    else if (a == `CSTA_OFS_IRQ_MASK)
      hit = 1'b1;
    return hit;
  endfunction : csta_mapped

  logic        setup_ph;
  logic        access_ph;
  logic        wr_acc;
  logic        rd_acc;

  assign setup_ph  = PSEL && !PENABLE;
  assign access_ph = PSEL && PENABLE;
  assign wr_acc    = access_ph && PWRITE && csta_mapped(PADDR);
  assign rd_acc    = access_ph && !PWRITE && csta_mapped(PADDR);
  assign PREADY    = 1'b1;
  assign PSLVERR   = access_ph && !csta_mapped(PADDR);

  // ----------------------------------------
  // Extra input synchronisers
  // ----------------------------------------
  logic [1:0] ext_s1;
  logic [1:0] ext_s2;
  logic [1:0] next_ext_s1;
  logic [1:0] next_ext_s2;

  always_comb
  begin
    next_ext_s1 = {EXTRA_TRIP_IN, EXTRA_START_IN};
    next_ext_s2 = ext_s1;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      ext_s1 <= 2'h0;
      ext_s2 <= 2'h0;
    end
    else
    begin
      ext_s1 <= next_ext_s1;
      ext_s2 <= next_ext_s2;
    end
  end

  // ----------------------------------------
  // Settings registers
  // ----------------------------------------
  // Held apart from any setting group, so a group change leaves them alone
  csta_state_e force_sel;
  logic [3:0]  evt_sel;
  logic [3:0]  irq_mask;
  csta_state_e next_force_sel;
  logic [3:0]  next_evt_sel;
  logic [3:0]  next_irq_mask;
  logic        clr_start;
  logic        clr_trip;

  always_comb
  begin
    next_force_sel = force_sel;
    next_evt_sel   = evt_sel;
    next_irq_mask  = irq_mask;
    clr_start      = 1'b0;
    clr_trip       = 1'b0;
    if (wr_acc && PADDR == `CSTA_OFS_CTRL)
    begin
      if (PWDATA[`CSTA_CTRL_FORCE_MSB:`CSTA_CTRL_FORCE_LSB] <= 2'h2)
        next_force_sel = csta_state_e'(PWDATA[`CSTA_CTRL_FORCE_MSB:`CSTA_CTRL_FORCE_LSB]);
      clr_start = PWDATA[`CSTA_CTRL_CLR_START];
      clr_trip  = PWDATA[`CSTA_CTRL_CLR_TRIP];
    end
    else if (wr_acc && PADDR == `CSTA_OFS_EVT_SEL)
      next_evt_sel = PWDATA[3:0];
    else if (wr_acc && PADDR == `CSTA_OFS_IRQ_MASK)
      next_irq_mask = PWDATA[3:0];
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      force_sel <= csta_state_e'(`CSTA_RST_FORCE);
      evt_sel   <= `CSTA_RST_EVT_SEL;
      irq_mask  <= `CSTA_RST_IRQ_MASK;
    end
    else
    begin
      force_sel <= next_force_sel;
      evt_sel   <= next_evt_sel;
      irq_mask  <= next_irq_mask;
    end
  end

  // ----------------------------------------
  // Aggregation
  // ----------------------------------------
  csta_state_e force_eff;
  logic        next_start;
  logic        next_trip;

  // No blocking term anywhere on this path
  always_comb
  begin
    force_eff  = STAGE_FORCE_EN ? force_sel : CSTA_NORMAL;
    next_start = (|PROT_START) || ext_s2[0];
    next_trip  = (|PROT_TRIP) || ext_s2[1];
    if (force_eff == CSTA_START)
      next_start = 1'b1;
    else if (force_eff == CSTA_TRIP)
      next_trip = 1'b1;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      COMMON_START <= 1'b0;
      COMMON_TRIP  <= 1'b0;
    end
    else
    begin
      COMMON_START <= next_start;
      COMMON_TRIP  <= next_trip;
    end
  end

  // ----------------------------------------
  // Edge detection and event logging
  // ----------------------------------------
  logic [1:0]  out_now;
  logic [1:0]  out_prev;
  logic [1:0]  chg;
  logic [1:0]  keep;
  logic [31:0] time_ms;
  csta_evt_s   next_evt;
  logic        next_evt_valid;
  logic        next_main_valid;

  assign out_now = {COMMON_TRIP, COMMON_START};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_chan
      assign chg[g]  = out_now[g] ^ out_prev[g];
      assign keep[g] = chg[g] && (out_now[g] ? evt_sel[2*g] : evt_sel[2*g+1]);
    end
  endgenerate

  always_comb
  begin
    next_evt           = EVT;
    next_evt_valid     = |chg;
    next_main_valid    = |keep;
    if (|chg)
    begin
      next_evt.time_ms   = time_ms;
      next_evt.proc_data = PROC_DATA;
      next_evt.start_chg = chg[0];
      next_evt.start_on  = out_now[0];
      next_evt.trip_chg  = chg[1];
      next_evt.trip_on   = out_now[1];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      out_prev       <= 2'h0;
      EVT            <= '0;
      EVT_VALID      <= 1'b0;
      MAIN_EVT_VALID <= 1'b0;
    end
    else
    begin
      out_prev       <= out_now;
      EVT            <= next_evt;
      EVT_VALID      <= next_evt_valid;
      MAIN_EVT_VALID <= next_main_valid;
    end
  end

  csta_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk      (SYS_CLK),
    .nrst     (NRST),
    .tick     (),
    .ms_count (time_ms)
  );

  // ----------------------------------------
  // Cumulative counters
  // ----------------------------------------
  logic [31:0] start_cnt;
  logic [31:0] trip_cnt;

  csta_evt_counter u_start_cnt (
    .clk   (SYS_CLK),
    .nrst  (NRST),
    .inc   (chg[0] && out_now[0]),
    .clr   (clr_start),
    .count (start_cnt)
  );

  csta_evt_counter u_trip_cnt (
    .clk   (SYS_CLK),
    .nrst  (NRST),
    .inc   (chg[1] && out_now[1]),
    .clr   (clr_trip),
    .count (trip_cnt)
  );

  // ----------------------------------------
  // Condition code
  // ----------------------------------------
  csta_state_e cond;

  always_comb
  begin
    if (COMMON_TRIP)
      cond = CSTA_TRIP;
    else if (COMMON_START)
      cond = CSTA_START;
    else
      cond = CSTA_NORMAL;
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic [3:0] irq_stat;
  logic [3:0] irq_snap;
  logic [3:0] irq_set;
  logic [3:0] next_irq_stat;
  logic       next_irq;

  assign irq_set = {chg[1] && !out_now[1], chg[1] && out_now[1],
                    chg[0] && !out_now[0], chg[0] && out_now[0]};

  // Only bits shown to software are cleared; a new set wins
  always_comb
  begin
    next_irq_stat = irq_stat;
    if (rd_acc && PADDR == `CSTA_OFS_IRQ_STAT)
      next_irq_stat = irq_stat & ~irq_snap;
    next_irq_stat = next_irq_stat | irq_set;
    next_irq      = |(next_irq_stat & irq_mask);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      irq_stat <= 4'h0;
      IRQ      <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      IRQ      <= next_irq;
    end
  end

  // ----------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------
  logic [31:0] next_prdata;
  logic [3:0]  next_irq_snap;

  always_comb
  begin
    next_prdata   = PRDATA;
    next_irq_snap = irq_snap;
    if (setup_ph && !PWRITE)
    begin
      next_prdata   = 32'h0;
      next_irq_snap = 4'h0;
      if (PADDR == `CSTA_OFS_CTRL)
        next_prdata[`CSTA_CTRL_FORCE_MSB:`CSTA_CTRL_FORCE_LSB] = force_sel;
      else if (PADDR == `CSTA_OFS_EVT_SEL)
        next_prdata[3:0] = evt_sel;
      else if (PADDR == `CSTA_OFS_COND)
      begin
        next_prdata[`CSTA_COND_CODE_MSB:`CSTA_COND_CODE_LSB] = cond;
        next_prdata[`CSTA_COND_START]    = COMMON_START;
        next_prdata[`CSTA_COND_TRIP]     = COMMON_TRIP;
        next_prdata[`CSTA_COND_FORCE_EN] = STAGE_FORCE_EN;
      end
      else if (PADDR == `CSTA_OFS_START_CNT)
        next_prdata = start_cnt;
      else if (PADDR == `CSTA_OFS_TRIP_CNT)
        next_prdata = trip_cnt;
      else if (PADDR == `CSTA_OFS_TIME_MS)
        next_prdata = time_ms;
      else if (PADDR == `CSTA_OFS_IRQ_STAT)
      begin
        next_prdata[3:0] = irq_stat;
        next_irq_snap    = irq_stat;
      end
      else if (PADDR == `CSTA_OFS_IRQ_MASK)
        next_prdata[3:0] = irq_mask;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      PRDATA   <= 32'h0;
      irq_snap <= 4'h0;
    end
    else
    begin
      PRDATA   <= next_prdata;
      irq_snap <= next_irq_snap;
    end
  end

endmodule : csta_common_signals

// File: csta_defines.svh
`ifndef CSTA_DEFINES_SVH
`define CSTA_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSTA_OFS_CTRL      8'h00
`define CSTA_OFS_EVT_SEL   8'h04
`define CSTA_OFS_COND      8'h08
`define CSTA_OFS_START_CNT 8'h0c
`define CSTA_OFS_TRIP_CNT  8'h10
`define CSTA_OFS_TIME_MS   8'h14
`define CSTA_OFS_IRQ_STAT  8'h18
`define CSTA_OFS_IRQ_MASK  8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSTA_CTRL_FORCE_LSB     0
`define CSTA_CTRL_FORCE_MSB     1
`define CSTA_CTRL_CLR_START     2
`define CSTA_CTRL_CLR_TRIP      3
`define CSTA_SEL_START_ON       0
`define CSTA_SEL_START_OFF      1
`define CSTA_SEL_TRIP_ON        2
`define CSTA_SEL_TRIP_OFF       3
`define CSTA_COND_CODE_LSB      0
`define CSTA_COND_CODE_MSB      1
`define CSTA_COND_START         2
`define CSTA_COND_TRIP          3
`define CSTA_COND_FORCE_EN      4
`define CSTA_IRQ_START_ON       0
`define CSTA_IRQ_START_OFF      1
`define CSTA_IRQ_TRIP_ON        2
`define CSTA_IRQ_TRIP_OFF       3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSTA_RST_FORCE     2'h0
`define CSTA_RST_EVT_SEL   4'hf
`define CSTA_RST_IRQ_MASK  4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSTA_CLK_MHZ       125
`define CSTA_TS_RES_MS     1
`define CSTA_MS_CYCLES     (`CSTA_TS_RES_MS * 1000 * `CSTA_CLK_MHZ)

`endif

// File: csta_pkg.sv
package csta_pkg;

  // Shared by force select and condition code
  typedef enum logic [1:0] {
    CSTA_NORMAL,
    CSTA_START,
    CSTA_TRIP
  } csta_state_e;

  // One logged record, covers both outputs
  typedef struct packed {
    logic [31:0] time_ms;
    logic [31:0] proc_data;
    logic        start_chg;
    logic        start_on;
    logic        trip_chg;
    logic        trip_on;
  } csta_evt_s;

endpackage : csta_pkg

// File: csta_ms_timer.sv
`timescale 1ns/1ps
`include "csta_defines.svh"

module csta_ms_timer
  import csta_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CSTA_MS_CYCLES
)
(
  input  wire logic        clk,     // System clock
  input  wire logic        nrst,    // Sync reset, low
  output logic             tick,    // One pulse per ms
  output logic [31:0]      ms_count // Free running ms count
);

  logic [31:0] pre;
  logic [31:0] next_pre;
  logic [31:0] next_ms_count;
  logic        next_tick;

  always_comb
  begin
    next_pre      = pre + 32'h1;
    next_tick     = 1'b0;
    next_ms_count = ms_count;
    if (pre >= 32'(MS_CYCLES - 1))
    begin
      next_pre      = 32'h0;
      next_tick     = 1'b1;
      next_ms_count = ms_count + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pre      <= 32'h0;
      tick     <= 1'b0;
      ms_count <= 32'h0;
    end
    else
    begin
      pre      <= next_pre;
      tick     <= next_tick;
      ms_count <= next_ms_count;
    end
  end

endmodule : csta_ms_timer

// File: csta_evt_counter.sv
`timescale 1ns/1ps

module csta_evt_counter
  import csta_pkg::*;
(
  input  wire logic        clk,   // System clock
  input  wire logic        nrst,  // Sync reset, low
  input  wire logic        inc,   // Count one event
  input  wire logic        clr,   // Clear request
  output logic [31:0]      count  // Cumulative count
);

  logic [31:0] next_count;

  // Event in the clearing cycle survives as one
  always_comb
  begin
    if (clr)
      next_count = inc ? 32'h1 : 32'h0;
    else if (inc)
      next_count = count + 32'h1;
    else
      next_count = count;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      count <= 32'h0;
    else
      count <= next_count;
  end

endmodule : csta_evt_counter

// File: csta_prot_model.sv
`timescale 1ns/1ps

module csta_prot_model
  import csta_pkg::*;
(
  input  wire logic        clk,        // System clock
  input  wire logic        nrst,       // Sync reset, low
  input  wire logic        start,      // Raise a start
  input  wire logic        trip,       // Raise a trip
  input  wire logic [3:0]  pick,       // Which function acts
  output logic      [15:0] prot_start, // Start levels
  output logic      [15:0] prot_trip   // Trip levels
);
  // One protection function at a time, registered like the real stages
  always_ff @(posedge clk)
  begin
    prot_start <= (nrst && start) ? (16'h0001 << pick) : 16'h0000;
    prot_trip  <= (nrst && trip) ? (16'h0001 << pick) : 16'h0000;
  end
endmodule : csta_prot_model

// File: csta_common_signals_checker.sv
`timescale 1ns/1ps

module csta_common_signals_checker
  import csta_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10
)
(
  input wire logic        SYS_CLK,        // Clock
  input wire logic        NRST,           // Reset
  input wire logic        PSEL,           // In
  input wire logic        PENABLE,        // In
  input wire logic        PWRITE,         // In
  input wire logic [7:0]  PADDR,          // In
  input wire logic [31:0] PWDATA,         // In
  input wire logic [15:0] PROT_START,     // In
  input wire logic [15:0] PROT_TRIP,      // In
  input wire logic        EXTRA_START_IN, // In
  input wire logic        STAGE_FORCE_EN, // In
  input wire logic        COMMON_START,   // Out
  input wire logic        COMMON_TRIP,    // Out
  input wire csta_evt_s   EVT,            // Out
  input wire logic        EVT_VALID,      // Out
  input wire logic        MAIN_EVT_VALID, // Out
  input wire logic        IRQ             // Out
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  property p_start_any; |PROT_START |=> COMMON_START; endproperty
  a_start_any: assert property (p_start_any)
    else $error("common start missed");
  property p_trip_any; |PROT_TRIP |=> COMMON_TRIP; endproperty
  a_trip_any: assert property (p_trip_any)
    else $error("common trip missed");
  property p_extra; EXTRA_START_IN [*3] |=> COMMON_START; endproperty
  a_extra: assert property (p_extra)
    else $error("extra start missed");
  property p_idle; (PROT_START == 16'h0000 && !EXTRA_START_IN && !STAGE_FORCE_EN) [*4] |=> !COMMON_START; endproperty
  a_idle: assert property (p_idle)
    else $error("common start without cause");
  property p_log; $changed({COMMON_START, COMMON_TRIP}) |=> EVT_VALID; endproperty
  a_log: assert property (p_log)
    else $error("event not logged");
  property p_quiet; $stable({COMMON_START, COMMON_TRIP}) |=> !EVT_VALID; endproperty
  a_quiet: assert property (p_quiet)
    else $error("event without change");
  property p_on; $rose(COMMON_TRIP) |=> EVT.trip_chg && EVT.trip_on; endproperty
  a_on: assert property (p_on)
    else $error("trip on record wrong");
  property p_main; MAIN_EVT_VALID |-> EVT_VALID; endproperty
  a_main: assert property (p_main)
    else $error("main event without record");
  property p_force;
    PSEL && PENABLE && PWRITE && PADDR == 8'h00 && PWDATA[1:0] == 2'h2 ##1 STAGE_FORCE_EN |=> COMMON_TRIP;
  endproperty
  a_force: assert property (p_force)
    else $error("forced trip missed");

  c_both: cover property (EVT_VALID && EVT.start_chg && EVT.trip_chg);
  c_main: cover property (MAIN_EVT_VALID);
  c_irq: cover property ($rose(IRQ));
endmodule : csta_common_signals_checker

// File: csta_common_signals_tb_top.sv
`timescale 1ns/1ps

module csta_common_signals_tb_top
  import csta_pkg::*;
;
  logic        SYS_CLK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PROC_DATA = 32'h0, PRDATA, q1, seed = 32'h0000fedc;
  logic        PREADY, PSLVERR, COMMON_START, COMMON_TRIP, EVT_VALID, MAIN_EVT_VALID, IRQ;
  logic        EXTRA_START_IN = 1'b0, EXTRA_TRIP_IN = 1'b0, STAGE_FORCE_EN = 1'b0;
  logic [15:0] PROT_START, PROT_TRIP;
  logic        m_start = 1'b0, m_trip = 1'b0, cs = 1'b0, ct = 1'b0;
  logic [3:0]  m_pick = 4'h0, stat = 4'h0, sel = 4'hf, mask = 4'h0;
  logic [1:0]  frc = 2'h0;
  csta_evt_s   EVT;
  int          fails = 0, compares = 0, ns = 0, nt = 0, cyc = 0;
  logic [32:0] rd_q[$];
  logic [36:0] ev_q[$];

  always #4 SYS_CLK = ~SYS_CLK;

  // Clock edges out of reset, for the expected ms stamp
  always @(posedge SYS_CLK)
  begin
    if (NRST)
      cyc <= cyc + 1;
  end

  csta_prot_model csta_prot_model_inst (.clk(SYS_CLK), .nrst(NRST), .start(m_start), .trip(m_trip),
    .pick(m_pick), .prot_start(PROT_START), .prot_trip(PROT_TRIP));
  csta_common_signals #(.MS_CYCLES(10)) csta_common_signals_inst (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PROT_START(PROT_START), .PROT_TRIP(PROT_TRIP), .EXTRA_START_IN(EXTRA_START_IN),
    .EXTRA_TRIP_IN(EXTRA_TRIP_IN), .STAGE_FORCE_EN(STAGE_FORCE_EN), .PROC_DATA(PROC_DATA),
    .COMMON_START(COMMON_START), .COMMON_TRIP(COMMON_TRIP), .EVT(EVT), .EVT_VALID(EVT_VALID),
    .MAIN_EVT_VALID(MAIN_EVT_VALID), .IRQ(IRQ));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string n, input logic e, input logic g);
    cmp_word(n, {31'h0, e}, {31'h0, g});
  endtask : cmp_bit

  task automatic report_and_stop();
    if (rd_q.size() + ev_q.size() != 0)
    begin
      fails++;
      $display("Error pending expected %0d seen 0", rd_q.size() + ev_q.size());
    end
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Bus master and stimulus
  // ----------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do
      @(posedge SYS_CLK);
    while (PREADY !== 1'b1);
    q = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic r = 1'b0);
    logic [31:0] q;
    rd_q.push_back({r, e});
    apb(a, 1'b0, 32'h0, q);
  endtask : rd

  task automatic step(input logic [1:0] p, input logic [1:0] x, input logic f, input logic [1:0] fv);
    logic        s, t;
    logic [3:0]  ch;
    logic [31:0] pd, q;
    if (fv != 2'h3)
      frc = fv;
    s = p[0] | x[0] | (f && frc == 2'h1);
    t = p[1] | x[1] | (f && frc == 2'h2);
    ch = {ct & ~t, t & ~ct, cs & ~s, s & ~cs};
    pd = rnd();
    if (ch != 4'h0)
      ev_q.push_back({pd, s != cs, s, t != ct, t, |(ch & sel)});
    stat = stat | ch;
    ns += ch[0];
    nt += ch[2];
    cs = s;
    ct = t;
    PROC_DATA <= pd;
    m_start <= p[0];
    m_trip <= p[1];
    m_pick <= pd[3:0];
    EXTRA_START_IN <= x[0];
    EXTRA_TRIP_IN <= x[1];
    STAGE_FORCE_EN <= f;
    apb(8'h00, 1'b1, {30'h0, fv}, q);
    repeat (8) @(posedge SYS_CLK);
    cmp_bit("common_start", s, COMMON_START);
    cmp_bit("common_trip", t, COMMON_TRIP);
    cmp_bit("irq", |(stat & mask), IRQ);
  endtask : step

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(negedge SYS_CLK)
  begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PWRITE === 1'b0 && PREADY === 1'b1 && rd_q.size() > 0)
    begin
      cmp_word("prdata", rd_q[0][31:0], PRDATA);
      cmp_bit("pslverr", rd_q[0][32], PSLVERR);
      void'(rd_q.pop_front());
    end
    if (EVT_VALID === 1'b1 && ev_q.size() > 0)
    begin
      cmp_word("evt_data", ev_q[0][36:5], EVT.proc_data);
      cmp_word("evt_time", 32'((cyc - 1) / 10), EVT.time_ms);
      cmp_word("evt_flags", {28'h0, ev_q[0][4:1]}, {28'h0, EVT.start_chg, EVT.start_on, EVT.trip_chg, EVT.trip_on});
      cmp_bit("main_evt", ev_q[0][0], MAIN_EVT_VALID);
      void'(ev_q.pop_front());
    end
    else if (EVT_VALID !== 1'b0)
    begin
      fails++;
      $display("Error evt_valid expected 0 seen %b", EVT_VALID);
    end
  end

  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    fails++;
    $display("Error watchdog expected done seen running");
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(posedge SYS_CLK);
    for (int i = 0; i < 9; i++)
      if (i != 5)
        rd(8'(i * 4), (i == 1) ? 32'hf : 32'h0, i == 8);
    apb(8'h08, 1'b1, 32'hff, q1);
    rd(8'h08, 32'h0);
    mask = 4'h5;
    apb(8'h1c, 1'b1, 32'h5, q1);
    rd(8'h1c, 32'h5);
    for (int i = 0; i < 4; i++)
    begin
      q1 = rnd();
      sel = q1[3:0];
      apb(8'h04, 1'b1, {28'h0, sel}, q1);
      step(2'h1, 2'h0, 1'b0, 2'h0);
      step(2'h3, 2'h0, 1'b0, 2'h0);
      rd(8'h08, 32'h0000000e);
      step(2'h2, 2'h0, 1'b0, 2'h0);
      step(2'h0, 2'h0, 1'b0, 2'h0);
    end
    rd(8'h0c, 32'(ns));
    rd(8'h10, 32'(nt));
    rd(8'h18, {28'h0, stat});
    stat = 4'h0;
    repeat (2) @(posedge SYS_CLK);
    cmp_bit("irq", 1'b0, IRQ);
    step(2'h0, 2'h1, 1'b0, 2'h0);
    step(2'h0, 2'h3, 1'b0, 2'h0);
    step(2'h0, 2'h0, 1'b0, 2'h0);
    sel = 4'hf;
    apb(8'h04, 1'b1, 32'hf, q1);
    step(2'h0, 2'h0, 1'b0, 2'h2);
    rd(8'h00, 32'h2);
    rd(8'h08, 32'h0);
    step(2'h0, 2'h0, 1'b1, 2'h2);
    rd(8'h08, 32'h1a);
    step(2'h0, 2'h0, 1'b1, 2'h1);
    step(2'h0, 2'h0, 1'b1, 2'h3);
    rd(8'h00, 32'h1);
    step(2'h2, 2'h0, 1'b1, 2'h1);
    step(2'h0, 2'h0, 1'b1, 2'h1);
    step(2'h0, 2'h0, 1'b0, 2'h0);
    apb(8'h00, 1'b1, 32'hc, q1);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h0);
    apb(8'h14, 1'b0, 32'h0, q1);
    repeat (47) @(posedge SYS_CLK);
    rd(8'h14, q1 + 32'h5);
    repeat (4) @(posedge SYS_CLK);
    report_and_stop();
  end
endmodule : csta_common_signals_tb_top

bind csta_common_signals csta_common_signals_checker #(.MS_CYCLES(MS_CYCLES)) csta_common_signals_checker_inst (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PROT_START(PROT_START), .PROT_TRIP(PROT_TRIP), .EXTRA_START_IN(EXTRA_START_IN),
  .STAGE_FORCE_EN(STAGE_FORCE_EN), .COMMON_START(COMMON_START), .COMMON_TRIP(COMMON_TRIP), .EVT(EVT),
  .EVT_VALID(EVT_VALID), .MAIN_EVT_VALID(MAIN_EVT_VALID), .IRQ(IRQ));
